// ===== adc_ctrl_regs.vh
// Register offsets, field positions, reset values and timing for converter control
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

`define OFS_TRIG_CTRL 12'h000
`define OFS_CAL 12'h004
`define OFS_IRQ_STATUS 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_CORE_STATUS 12'h010

`define TRIG_CTRL_RESET 16'h0000
`define CAL_RESET 16'h0000

`define F_REFERENCE_SELECT_HI 15
`define F_REFERENCE_SELECT_LO 13
`define F_SUSPEND 12
`define F_HOLD_IRQ_EN 11
`define F_HOLD_DONE 10
`define F_SHR_SAMP 9
`define F_CH_TRIG 8
`define F_LVL_TRIG 7
`define F_PULSE_TRIG 6
`define F_CHSEL_HI 5

`define F_C1_DONE 15
`define F_C1_DIFF 10
`define F_C1_EN 9
`define F_C1_START 8
`define F_C0_DONE 7
`define F_C0_DIFF 2
`define F_C0_EN 1
`define F_C0_START 0

`define IRQ_HOLD_DONE 0
`define IRQ_CAL0_DONE 1
`define IRQ_CAL1_DONE 2

`define CAL_TIME_NS 1000
`define CLK_PERIOD_NS 8
`define CAL_CYCLES ((`CAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== adc_cal_engine.v
// Calibration sequencer for one dedicated converter core
`timescale 1ns/100ps
`default_nettype none

module adc_cal_engine
(
    input wire clk_in,
    input wire rst_in,
    input wire start_in,
    output reg busy_out,
    output reg done_out
);

`include "adc_ctrl_regs.vh"

localparam [31:0] CAL_COUNT_FULL = `CAL_CYCLES;
localparam [7:0] CAL_COUNT = CAL_COUNT_FULL[7:0];

reg [7:0] count_reg;

// Runs a fixed-length cycle, pulses done at its end
always @(posedge clk_in)
begin
    if (rst_in)
    begin
        count_reg <= 8'h00;
        busy_out <= 1'b0;
        done_out <= 1'b0;
    end
    else
    begin
        done_out <= 1'b0;
        if (start_in && !busy_out)
        begin
            busy_out <= 1'b1;
            count_reg <= CAL_COUNT;
        end
        else if (busy_out)
        begin
            if (count_reg == 8'h01)
            begin
                busy_out <= 1'b0;
                done_out <= 1'b1;
            end
            count_reg <= count_reg - 8'h01;
        end
    end
end

endmodule // adc_cal_engine

`default_nettype wire

// ===== adc_trigger_ctrl.v
// Converter trigger, suspend and calibration control with APB registers
// Operation
// - Reference select code 000 picks analog supply pair; other codes unused.
// - Suspend bit set blocks every new trigger to all cores.
// - Suspend interrupt enable raises common interrupt when hold-done flag sets.
// - Hold-done flag reads 1 only while suspended with no conversion running.
// - Direct sampling bit connects selected channel to shared core, keeps sampling.
// - Single-channel trigger issues one trigger, self-clears next cycle.
// - Level common trigger continuously triggers while set.
// - Pulse common trigger issues one trigger, self-clears next cycle.
// - Six-bit channel select names the channel for single-channel trigger.
// - Calibration enable gates access to ready, mode and start bits.
// - Calibration mode bit: 1 differential, 0 single-ended.
`timescale 1ns/100ps
`default_nettype none

module adc_trigger_ctrl
(
    input wire CLOCK_IN,
    input wire RST_IN,
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output reg PREADY_OUT,
    output reg PSLVERR_OUT,
    input wire [4:0] CORE_BUSY_IN,
    output reg [2:0] REF_SELECT_OUT,
    output reg CH_TRIGGER_OUT,
    output reg [5:0] CHANNEL_SELECT_OUT,
    output reg PULSE_COMMON_TRIGGER_OUT,
    output reg LEVEL_COMMON_TRIGGER_OUT,
    output reg SHARED_SAMPLE_OUT,
    output reg CORE0_CAL_RUN_OUT,
    output reg CORE0_CAL_DIFF_OUT,
    output reg CORE1_CAL_RUN_OUT,
    output reg CORE1_CAL_DIFF_OUT,
    output reg IRQ_OUT
);

`include "adc_ctrl_regs.vh"

function addr_hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
        addr_hit = (a == ofs);
    end
endfunction

// Per-core calibration byte, ready low while started or running
function [7:0] cal_byte;
    input en;
    input busy;
    input diff;
    input start;
    begin
        cal_byte = 8'h00;
        cal_byte[7] = en & ~busy & ~start;
        cal_byte[2] = diff;
        cal_byte[1] = en;
        cal_byte[0] = start;
    end
endfunction

// Mode and start bits are writable with the old or the new enable
function cal_access;
    input old_en;
    input new_en;
    begin
        cal_access = old_en || new_en;
    end
endfunction

// A software trigger reaches the cores only while not suspended
function trig_gate;
    input request;
    input hold;
    begin
        trig_gate = request && !hold;
    end
endfunction

reg [15:0] trig_ctrl_reg;
reg [15:0] cal_reg;
reg [2:0] irq_status_reg;
reg [2:0] irq_mask_reg;
reg hold_done_prev_reg;
reg [15:0] trig_ctrl_next;
reg [31:0] rdata_next;

wire acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
wire wr = acc && PWRITE_IN;
wire access_first = PSEL_IN && PENABLE_IN && !PREADY_OUT;
wire hit_trig = addr_hit(PADDR_IN, `OFS_TRIG_CTRL);
wire hit_cal = addr_hit(PADDR_IN, `OFS_CAL);
wire hit_ist = addr_hit(PADDR_IN, `OFS_IRQ_STATUS);
wire hit_imk = addr_hit(PADDR_IN, `OFS_IRQ_MASK);
wire hit_cst = addr_hit(PADDR_IN, `OFS_CORE_STATUS);
wire mapped = hit_trig || hit_cal || hit_ist || hit_imk || hit_cst;

wire suspend = trig_ctrl_reg[`F_SUSPEND];
wire any_busy = |CORE_BUSY_IN;
wire hold_done = suspend && !any_busy;
wire c0_busy;
wire c1_busy;
wire c0_done;
wire c1_done;
wire hold_event = hold_done && !hold_done_prev_reg
    && trig_ctrl_reg[`F_HOLD_IRQ_EN];
wire [2:0] irq_set = {c1_done, c0_done, hold_event};
wire [2:0] irq_clear = (wr && hit_ist) ? PWDATA_IN[2:0] : 3'h0;

adc_cal_engine cal0
(
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .start_in(cal_reg[`F_C0_START]),
    .busy_out(c0_busy),
    .done_out(c0_done)
);

adc_cal_engine cal1
(
    .clk_in(CLOCK_IN),
    .rst_in(RST_IN),
    .start_in(cal_reg[`F_C1_START]),
    .busy_out(c1_busy),
    .done_out(c1_done)
);

// Readback view with hardware flags merged in
wire [15:0] trig_view = {trig_ctrl_reg[15:11], hold_done,
    trig_ctrl_reg[9:0]};
wire [15:0] cal_view = {
    cal_byte(cal_reg[`F_C1_EN], c1_busy, cal_reg[`F_C1_DIFF],
        cal_reg[`F_C1_START]),
    cal_byte(cal_reg[`F_C0_EN], c0_busy, cal_reg[`F_C0_DIFF],
        cal_reg[`F_C0_START])};

// Next value of the trigger control register
always @*
begin
    trig_ctrl_next = trig_ctrl_reg;
    trig_ctrl_next[`F_CH_TRIG] = 1'b0;
    trig_ctrl_next[`F_PULSE_TRIG] = 1'b0;
    trig_ctrl_next[`F_HOLD_DONE] = 1'b0;
    if (wr && hit_trig)
    begin
        trig_ctrl_next[15:11] = PWDATA_IN[15:11];
        trig_ctrl_next[9:0] = PWDATA_IN[9:0];
    end
end

// Read data of the addressed register
always @*
begin
    rdata_next = 32'h00000000;
    case (PADDR_IN)
        `OFS_TRIG_CTRL:
            rdata_next = {16'h0000, trig_view};
        `OFS_CAL:
            rdata_next = {16'h0000, cal_view};
        `OFS_IRQ_STATUS:
            rdata_next = {29'h0000000, irq_status_reg};
        `OFS_IRQ_MASK:
            rdata_next = {29'h0000000, irq_mask_reg};
        `OFS_CORE_STATUS:
            rdata_next = {27'h0000000, CORE_BUSY_IN};
        default:
            rdata_next = 32'h00000000;
    endcase
end

// Trigger control register
always @(posedge CLOCK_IN)
begin
    if (RST_IN)
    begin
        trig_ctrl_reg <= `TRIG_CTRL_RESET;
    end
    else
    begin
        trig_ctrl_reg <= trig_ctrl_next;
    end
end

// Calibration register; access bits need the enable bit
always @(posedge CLOCK_IN)
begin
    if (RST_IN)
    begin
        cal_reg <= `CAL_RESET;
    end
    else
    begin
        if (c1_busy)
        begin
            cal_reg[`F_C1_START] <= 1'b0;
        end
        if (c0_busy)
        begin
            cal_reg[`F_C0_START] <= 1'b0;
        end
        if (wr && hit_cal)
        begin
            cal_reg[`F_C1_EN] <= PWDATA_IN[`F_C1_EN];
            cal_reg[`F_C0_EN] <= PWDATA_IN[`F_C0_EN];
            if (cal_access(cal_reg[`F_C1_EN], PWDATA_IN[`F_C1_EN]))
            begin
                cal_reg[`F_C1_DIFF] <= PWDATA_IN[`F_C1_DIFF];
                cal_reg[`F_C1_START] <= PWDATA_IN[`F_C1_START] & ~c1_busy;
            end
            if (cal_access(cal_reg[`F_C0_EN], PWDATA_IN[`F_C0_EN]))
            begin
                cal_reg[`F_C0_DIFF] <= PWDATA_IN[`F_C0_DIFF];
                cal_reg[`F_C0_START] <= PWDATA_IN[`F_C0_START] & ~c0_busy;
            end
        end
    end
end

// Sticky event flags, set wins over write-one-to-clear
always @(posedge CLOCK_IN)
begin
    if (RST_IN)
    begin
        irq_status_reg <= 3'h0;
        irq_mask_reg <= 3'h0;
        hold_done_prev_reg <= 1'b0;
    end
    else
    begin
        hold_done_prev_reg <= hold_done;
        if (wr && hit_imk)
        begin
            irq_mask_reg <= PWDATA_IN[2:0];
        end
        irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_set;
    end
end

// Registered outputs toward the converter cores and the interrupt output
always @(posedge CLOCK_IN)
begin
    if (RST_IN)
    begin
        REF_SELECT_OUT <= 3'h0;
        CH_TRIGGER_OUT <= 1'b0;
        CHANNEL_SELECT_OUT <= 6'h00;
        PULSE_COMMON_TRIGGER_OUT <= 1'b0;
        LEVEL_COMMON_TRIGGER_OUT <= 1'b0;
        SHARED_SAMPLE_OUT <= 1'b0;
        CORE0_CAL_RUN_OUT <= 1'b0;
        CORE0_CAL_DIFF_OUT <= 1'b0;
        CORE1_CAL_RUN_OUT <= 1'b0;
        CORE1_CAL_DIFF_OUT <= 1'b0;
        IRQ_OUT <= 1'b0;
    end
    else
    begin
        REF_SELECT_OUT <= trig_ctrl_reg[`F_REFERENCE_SELECT_HI:`F_REFERENCE_SELECT_LO];
        CHANNEL_SELECT_OUT <= trig_ctrl_reg[`F_CHSEL_HI:0];
        CH_TRIGGER_OUT <= trig_gate(trig_ctrl_reg[`F_CH_TRIG],
            suspend);
        PULSE_COMMON_TRIGGER_OUT <= trig_gate(trig_ctrl_reg[`F_PULSE_TRIG],
            suspend);
        LEVEL_COMMON_TRIGGER_OUT <= trig_gate(trig_ctrl_reg[`F_LVL_TRIG],
            suspend);
        SHARED_SAMPLE_OUT <= trig_ctrl_reg[`F_SHR_SAMP];
        CORE0_CAL_RUN_OUT <= c0_busy;
        CORE0_CAL_DIFF_OUT <= cal_reg[`F_C0_DIFF];
        CORE1_CAL_RUN_OUT <= c1_busy;
        CORE1_CAL_DIFF_OUT <= cal_reg[`F_C1_DIFF];
        IRQ_OUT <= |(irq_status_reg & irq_mask_reg);
    end
end

// APB slave: one wait state, error on unmapped address
always @(posedge CLOCK_IN)
begin
    if (RST_IN)
    begin
        PREADY_OUT <= 1'b0;
        PSLVERR_OUT <= 1'b0;
        PRDATA_OUT <= 32'h00000000;
    end
    else
    begin
        PREADY_OUT <= access_first;
        PSLVERR_OUT <= access_first && !mapped;
        PRDATA_OUT <= 32'h00000000;
        if (access_first && !PWRITE_IN)
        begin
            PRDATA_OUT <= rdata_next;
        end
    end
end

endmodule // adc_trigger_ctrl

`default_nettype wire

// ===== adc_trigger_ctrl_asserts.sv
// Port checker for the converter trigger control block
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_ctrl_chk
(
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic CH_TRIGGER_OUT,
    input wire logic PULSE_COMMON_TRIGGER_OUT,
    input wire logic CORE0_CAL_RUN_OUT,
    input wire logic CORE1_CAL_RUN_OUT
);
    wire wr = PREADY_OUT & PWRITE_IN;
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_ready_cause: assert property (PREADY_OUT |-> $past(PENABLE_IN))
        else $error("ready without access");
    a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside answer");
    a_ch_pulse: assert property (CH_TRIGGER_OUT |=> !CH_TRIGGER_OUT)
        else $error("channel trigger too wide");
    a_common_pulse: assert property
        (PULSE_COMMON_TRIGGER_OUT |=> !PULSE_COMMON_TRIGGER_OUT)
        else $error("common trigger too wide");
    a_ch_cause: assert property (CH_TRIGGER_OUT |->
        $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
        else $error("channel trigger without write");
    a_cal0_hold: assert property
        ($rose(CORE0_CAL_RUN_OUT) |=> CORE0_CAL_RUN_OUT[*8])
        else $error("core0 calibration too short");
    a_cal0_end: assert property
        ($rose(CORE0_CAL_RUN_OUT) |-> ##124 CORE0_CAL_RUN_OUT
            ##1 !CORE0_CAL_RUN_OUT)
        else $error("core0 calibration length wrong");
    a_cal1_end: assert property
        ($rose(CORE1_CAL_RUN_OUT) |-> ##124 CORE1_CAL_RUN_OUT
            ##1 !CORE1_CAL_RUN_OUT)
        else $error("core1 calibration length wrong");
endmodule // adc_trigger_ctrl_chk
bind adc_trigger_ctrl adc_trigger_ctrl_chk chk (.CLOCK_IN, .RST_IN,
    .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PRDATA_OUT, .PREADY_OUT,
    .PSLVERR_OUT, .CH_TRIGGER_OUT, .PULSE_COMMON_TRIGGER_OUT,
    .CORE0_CAL_RUN_OUT, .CORE1_CAL_RUN_OUT);
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the converter trigger control block
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_regs.vh"
module testbench;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, rd, seed = 90, v;
    logic [4:0] busy = 0;
    logic [31:0] prdata;
    logic pready, perr, cht, plt, lvt, shs, r0, d0, r1, d1, irq, e;
    logic [2:0] refs;
    logic [5:0] chs;
    int failures = 0, compares = 0, nch = 0, npl = 0, c, k, i;
    always #4 clk = ~clk;
    always @(posedge clk) nch <= nch + cht;
    always @(posedge clk) npl <= npl + plt;
    adc_trigger_ctrl dut (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(pd),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
        .CORE_BUSY_IN(busy), .REF_SELECT_OUT(refs),
        .CH_TRIGGER_OUT(cht), .CHANNEL_SELECT_OUT(chs),
        .PULSE_COMMON_TRIGGER_OUT(plt), .LEVEL_COMMON_TRIGGER_OUT(lvt),
        .SHARED_SAMPLE_OUT(shs), .CORE0_CAL_RUN_OUT(r0),
        .CORE0_CAL_DIFF_OUT(d0), .CORE1_CAL_RUN_OUT(r1),
        .CORE1_CAL_DIFF_OUT(d1), .IRQ_OUT(irq));
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] self_cleared(input logic [31:0] w);
        return w & ~((32'h1 << `F_CH_TRIG) | (32'h1 << `F_PULSE_TRIG));
    endfunction
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6000) @(posedge clk);
        failures++;
        test_done();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 0;
        chk("reference_select", refs, 0);
        apb(0, `OFS_TRIG_CTRL, 0);
        chk("trig reset", rd, `TRIG_CTRL_RESET);
        apb(0, `OFS_CAL, 0);
        chk("cal reset", rd, `CAL_RESET);
        apb(0, 12'h0FC, 0);
        chk("unmapped", {rd[30:0], e}, 1);
        for (i = 0; i < 4; i++)
        begin
            v = xs() & 32'h23F;
            apb(1, `OFS_TRIG_CTRL, v);
            apb(0, `OFS_TRIG_CTRL, 0);
            chk("trig rb", rd, v);
            chk("chsel", chs, v[5:0]);
            chk("shared", shs, v[9]);
        end
        for (k = 0; k < 2; k++)
        begin
            c = nch + npl;
            apb(1, `OFS_TRIG_CTRL, k ? 32'h40 : 32'h115);
            apb(0, `OFS_TRIG_CTRL, 0);
            chk("self clear", rd, self_cleared(k ? 32'h40 : 32'h115));
            repeat (4) @(posedge clk);
            chk("one trig", nch + npl - c, 1);
        end
        apb(1, `OFS_TRIG_CTRL, 32'h80);
        repeat (2) @(posedge clk);
        chk("level", lvt, 1);
        busy <= 5'h01;
        apb(1, `OFS_TRIG_CTRL, 32'h1880);
        repeat (2) @(posedge clk);
        chk("level blocked", lvt, 0);
        c = nch;
        apb(1, `OFS_TRIG_CTRL, 32'h1900);
        repeat (4) @(posedge clk);
        chk("blocked", nch - c, 0);
        apb(0, `OFS_TRIG_CTRL, 0);
        chk("hold busy", rd[10], 0);
        busy <= 0;
        apb(0, `OFS_TRIG_CTRL, 0);
        chk("hold done", rd[10], 1);
        apb(0, `OFS_IRQ_STATUS, 0);
        chk("irq status", rd[0], 1);
        apb(1, `OFS_IRQ_MASK, 0);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 0);
        apb(1, `OFS_IRQ_MASK, 7);
        repeat (2) @(posedge clk);
        chk("irq mask", irq, 1);
        apb(1, `OFS_IRQ_STATUS, 1);
        apb(1, `OFS_TRIG_CTRL, 0);
        chk("irq clear", irq, 0);
        apb(1, `OFS_TRIG_CTRL, 32'h1000);
        apb(0, `OFS_IRQ_STATUS, 0);
        chk("no hold irq", rd, 0);
        apb(1, `OFS_TRIG_CTRL, 0);
        for (k = 0; k < 2; k++)
        begin
            apb(1, `OFS_CAL, 4 << 8 * k);
            apb(0, `OFS_CAL, 0);
            chk("cal gated", rd, 0);
            apb(1, `OFS_CAL, 6 << 8 * k);
            apb(0, `OFS_CAL, 0);
            chk("cal diff", rd, 32'h86 << 8 * k);
            chk("diff out", k ? d1 : d0, 1);
            apb(1, `OFS_CAL, 7 << 8 * k);
            apb(0, `OFS_CAL, 0);
            chk("cal run", {k ? r1 : r0, rd[7 + 8 * k]}, 2);
            repeat (`CAL_CYCLES + 10) @(posedge clk);
            apb(0, `OFS_CAL, 0);
            chk("cal done", rd, 32'h86 << 8 * k);
            apb(0, `OFS_IRQ_STATUS, 0);
            chk("cal irq", rd, 2 << k);
            chk("cal irq out", irq, 1);
            apb(1, `OFS_IRQ_STATUS, 7);
            apb(1, `OFS_CAL, 0);
        end
        test_done();
    end
endmodule // testbench
`default_nettype wire
